// File: intr_pkg.sv
package intr_pkg;
   // ****************************************
   // instruction codes
   // ****************************************
   localparam logic [7:0] OP_ENABLE = 8'h19;
   localparam logic [7:0] OP_DISABLE = 8'h1A;
   localparam logic [7:0] OP_VECTOR = 8'h25;
   localparam logic [7:0] OP_RETURN = 8'h26;
   localparam logic [7:0] OP_USER_FIRST = 8'h40;
   localparam logic [7:0] OP_USER_LAST = 8'h47;
   localparam logic [7:0] GLOBAL_NUM = 8'hFF;
   // ****************************************
   // replies and widths
   // ****************************************
   localparam logic [7:0] STATUS_OK = 8'h64;
   localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
   localparam logic [7:0] STATUS_BAD_SUM = 8'h01;
   localparam logic [7:0] STATUS_BAD_MODE = 8'h05;
   localparam int NUM_IRQ = 16;
   localparam int IRQ_W = 4;
   localparam int PC_W = 16;
   localparam int XREG_W = 32;
   localparam int NUM_XREG = 4;
   localparam int FLAG_W = 8;
   localparam int FRAME_BYTES = 9;
   localparam logic [3:0] IDX_OP = 4'h1;
   localparam logic [3:0] IDX_TYPE = 4'h2;
   localparam logic [3:0] IDX_SUM = 4'h8;
   localparam logic [7:0] SUM_ZERO = 8'h00;
   localparam logic [3:0] IDX_ZERO = 4'h0;
   localparam logic [3:0] IDX_ONE = 4'h1;
   typedef enum logic [1:0] {run_st, enter_st, in_handler_st} exec_state_t;
endpackage

// File: frame_rx.sv
`timescale 1ns/1ps
// ****************************************
// host frame assembler with checksum check
// ****************************************
module frame_rx (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   output logic frame_valid,
   output logic sum_ok,
   output logic [7:0] opcode,
   output logic [7:0] type_num,
   output logic [31:0] value
);
   logic [3:0] idx;
   logic [7:0] sum;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         idx <= intr_pkg::IDX_ZERO;
         sum <= intr_pkg::SUM_ZERO;
         frame_valid <= 1'b0;
         sum_ok <= 1'b0;
         opcode <= 8'h00;
         type_num <= 8'h00;
         value <= 32'h00000000;
      end else begin
         frame_valid <= 1'b0;
         if (byte_valid) begin
            if (idx == intr_pkg::IDX_SUM) begin
               // checksum is low byte of the plain sum
               frame_valid <= 1'b1;
               sum_ok <= (sum == byte_data);
               idx <= intr_pkg::IDX_ZERO;
               sum <= intr_pkg::SUM_ZERO;
            end else begin
               sum <= sum + byte_data;
               idx <= idx + intr_pkg::IDX_ONE;
               if (idx == intr_pkg::IDX_OP) opcode <= byte_data;
               if (idx == intr_pkg::IDX_TYPE) type_num <= byte_data;
               if (idx > intr_pkg::IDX_TYPE + intr_pkg::IDX_ONE) value <= {value[23:0], byte_data};
            end
         end
      end
   end
endmodule

// File: intr_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - code 26 disables the interrupt named in type; other fields ignored
// - disable with number 255 turns interrupt processing off globally
// - global disable frame is 1A, FF, zero value, checksum 1A
// - code 37 stores value field as handler address for type number
// - a stored handler address may be overwritten later
// - vector and return codes belong to stored programs, not host link
// - code 38 ends the handler and resumes interrupted flow
// - return restores accumulator, X registers, flags and program counter
// - codes 64 to 71 are user functions replying status 100
// - code 25 enables named interrupt; 255 enables globally
module intr_ctrl (
   input wire logic sys_clk,
   input wire logic nrst,
   // host byte stream, same clock domain
   input wire logic host_byte_valid,
   input wire logic [7:0] host_byte,
   // stored-program instruction issue
   input wire logic prog_valid,
   input wire logic [7:0] prog_opcode,
   input wire logic [7:0] prog_type,
   input wire logic [31:0] prog_value,
   // execution context of the interpreter
   input wire logic [31:0] cur_accu,
   input wire logic [31:0] cur_xreg0,
   input wire logic [31:0] cur_xreg1,
   input wire logic [31:0] cur_xreg2,
   input wire logic [31:0] cur_xreg3,
   input wire logic [7:0] cur_flags,
   input wire logic [15:0] cur_pc,
   // asynchronous interrupt sources
   input wire logic [15:0] irq_req,
   output logic reply_valid,
   output logic [7:0] reply_status,
   output logic user_func_valid,
   output logic [2:0] user_func_num,
   output logic [15:0] irq_enable,
   output logic global_enable,
   output logic in_handler,
   output logic load_valid,
   output logic [15:0] load_pc,
   output logic [31:0] load_accu,
   output logic [31:0] load_xreg0,
   output logic [31:0] load_xreg1,
   output logic [31:0] load_xreg2,
   output logic [31:0] load_xreg3,
   output logic [7:0] load_flags
);
   // ****************************************
   // host frames
   // ****************************************
   logic host_frame;
   logic host_sum_ok;
   logic [7:0] host_op;
   logic [7:0] host_type;
   logic [31:0] host_value;
   frame_rx u_rx (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .byte_valid(host_byte_valid),
      .byte_data(host_byte),
      .frame_valid(host_frame),
      .sum_ok(host_sum_ok),
      .opcode(host_op),
      .type_num(host_type),
      .value(host_value)
   );
   // ****************************************
   // instruction select
   // ****************************************
   logic issue;
   logic [7:0] op;
   logic [7:0] tnum;
   logic [31:0] val;
   logic from_host;
   logic [3:0] inum;
   logic is_user;
   // host frame has priority; program issue is held off the same cycle
   assign from_host = host_frame;
   assign issue = (host_frame && host_sum_ok) || (prog_valid && !host_frame);
   assign op = from_host ? host_op : prog_opcode;
   assign tnum = from_host ? host_type : prog_type;
   assign val = from_host ? host_value : prog_value;
   assign inum = tnum[intr_pkg::IRQ_W-1:0];
   assign is_user = (op >= intr_pkg::OP_USER_FIRST) && (op <= intr_pkg::OP_USER_LAST);
   // ****************************************
   // irq synchroniser
   // ****************************************
   logic [15:0] irq_s1;
   logic [15:0] irq_s2;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq_s1 <= 16'h0000;
         irq_s2 <= 16'h0000;
      end else begin
         irq_s1 <= irq_req;
         irq_s2 <= irq_s1;
      end
   end
   // ****************************************
   // enables
   // ****************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         global_enable <= 1'b0;
      end else if (issue && tnum == intr_pkg::GLOBAL_NUM) begin
         if (op == intr_pkg::OP_DISABLE) global_enable <= 1'b0;
         if (op == intr_pkg::OP_ENABLE) global_enable <= 1'b1;
      end
   end
   genvar g;
   generate
      for (g = 0; g < intr_pkg::NUM_IRQ; g++) begin : g_en
         always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
               irq_enable[g] <= 1'b0;
            end else if (issue && tnum != intr_pkg::GLOBAL_NUM && inum == g[intr_pkg::IRQ_W-1:0]) begin
               if (op == intr_pkg::OP_DISABLE) irq_enable[g] <= 1'b0;
               if (op == intr_pkg::OP_ENABLE) irq_enable[g] <= 1'b1;
            end
         end
      end
   endgenerate
   // ****************************************
   // vector table
   // ****************************************
   logic [15:0] vec_table [intr_pkg::NUM_IRQ];
   logic ctrl_prog;
   assign ctrl_prog = issue && !from_host;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < intr_pkg::NUM_IRQ; i++) vec_table[i] <= 16'h0000;
      end else if (ctrl_prog && op == intr_pkg::OP_VECTOR) begin
         // later definitions simply replace earlier ones
         vec_table[inum] <= val[intr_pkg::PC_W-1:0];
      end
   end
   // ****************************************
   // entry and return
   // ****************************************
   intr_pkg::exec_state_t state;
   logic [15:0] pend;
   logic [3:0] sel;
   logic any_pend;
   logic [31:0] sv_accu;
   logic [31:0] sv_x [intr_pkg::NUM_XREG];
   logic [7:0] sv_flags;
   logic [15:0] sv_pc;
   assign pend = irq_s2 & irq_enable;
   assign any_pend = global_enable && (pend != 16'h0000);
   always_comb begin
      sel = 4'h0;
      for (int i = intr_pkg::NUM_IRQ - 1; i >= 0; i--) if (pend[i]) sel = 4'(i);
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state <= intr_pkg::run_st;
         in_handler <= 1'b0;
         load_valid <= 1'b0;
         load_pc <= 16'h0000;
         load_accu <= 32'h00000000;
         load_xreg0 <= 32'h00000000;
         load_xreg1 <= 32'h00000000;
         load_xreg2 <= 32'h00000000;
         load_xreg3 <= 32'h00000000;
         load_flags <= 8'h00;
         sv_accu <= 32'h00000000;
         sv_x <= '{default: 32'h00000000};
         sv_flags <= 8'h00;
         sv_pc <= 16'h0000;
      end else begin
         load_valid <= 1'b0;
         case (state)
            intr_pkg::run_st: begin
               if (any_pend) begin
                  // save context then jump to the vector
                  sv_accu <= cur_accu;
                  sv_x <= '{cur_xreg0, cur_xreg1, cur_xreg2, cur_xreg3};
                  sv_flags <= cur_flags;
                  sv_pc <= cur_pc;
                  load_pc <= vec_table[sel];
                  load_accu <= cur_accu;
                  load_xreg0 <= cur_xreg0;
                  load_xreg1 <= cur_xreg1;
                  load_xreg2 <= cur_xreg2;
                  load_xreg3 <= cur_xreg3;
                  load_flags <= cur_flags;
                  load_valid <= 1'b1;
                  in_handler <= 1'b1;
                  state <= intr_pkg::in_handler_st;
               end
            end
            intr_pkg::in_handler_st: begin
               // nesting not supported: new requests wait for return
               if (ctrl_prog && op == intr_pkg::OP_RETURN) begin
                  load_pc <= sv_pc;
                  load_accu <= sv_accu;
                  load_xreg0 <= sv_x[0];
                  load_xreg1 <= sv_x[1];
                  load_xreg2 <= sv_x[2];
                  load_xreg3 <= sv_x[3];
                  load_flags <= sv_flags;
                  load_valid <= 1'b1;
                  in_handler <= 1'b0;
                  state <= intr_pkg::run_st;
               end
            end
            default: state <= intr_pkg::run_st;
         endcase
      end
   end
   // ****************************************
   // reply and user functions
   // ****************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         reply_valid <= 1'b0;
         reply_status <= 8'h00;
         user_func_valid <= 1'b0;
         user_func_num <= 3'h0;
      end else begin
         reply_valid <= host_frame;
         user_func_valid <= issue && is_user;
         user_func_num <= op[2:0];
         if (host_frame) begin
            if (!host_sum_ok) reply_status <= intr_pkg::STATUS_BAD_SUM;
            else if (host_op == intr_pkg::OP_VECTOR || host_op == intr_pkg::OP_RETURN)
               reply_status <= intr_pkg::STATUS_BAD_MODE;
            else if (host_op == intr_pkg::OP_ENABLE || host_op == intr_pkg::OP_DISABLE || is_user)
               reply_status <= intr_pkg::STATUS_OK;
            else reply_status <= intr_pkg::STATUS_BAD_CMD;
         end
      end
   end
   // ****************************************
   // checks
   // ****************************************
   sequence sq_return;
      ctrl_prog && op == intr_pkg::OP_RETURN && state == intr_pkg::in_handler_st;
   endsequence
   sequence sq_restore;
      load_valid && load_pc == $past(sv_pc) && !in_handler;
   endsequence
   global_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      issue && op == intr_pkg::OP_DISABLE && tnum == intr_pkg::GLOBAL_NUM |=> !global_enable)
      else $error("global disable ignored");
   global_on_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      issue && op == intr_pkg::OP_ENABLE && tnum == intr_pkg::GLOBAL_NUM |=> global_enable)
      else $error("global enable ignored");
   single_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      issue && op == intr_pkg::OP_DISABLE && tnum < 8'h10 |=> !irq_enable[$past(inum)])
      else $error("single disable ignored");
   vector_store_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      ctrl_prog && op == intr_pkg::OP_VECTOR |=> vec_table[$past(inum)] == $past(val[15:0]))
      else $error("vector not stored");
   return_restore_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      sq_return |=> sq_restore)
      else $error("context not restored");
   entry_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(in_handler) |-> $past(global_enable) && load_valid)
      else $error("entry without enable");
   host_vector_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      host_frame && host_sum_ok && host_op == intr_pkg::OP_VECTOR |=> reply_status == intr_pkg::STATUS_BAD_MODE)
      else $error("host vector accepted");
   reply_ok_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      host_frame && host_sum_ok && (host_op == intr_pkg::OP_DISABLE || is_user)
      |=> reply_valid && reply_status == intr_pkg::STATUS_OK)
      else $error("missing ok reply");
endmodule

// File: host_link_model.sv
`timescale 1ns/1ps
// ****************************************
// host side: sends framed commands
// ****************************************
module host_link_model (
   input wire logic sys_clk,
   output logic host_byte_valid,
   output logic [7:0] host_byte
);
   initial begin
      host_byte_valid = 1'b0;
      host_byte = 8'hA5;
   end
   // interrupt number always travels in the type byte
   task automatic send(input logic [7:0] op, typ, input logic [31:0] val, input logic bad, input int gap);
      logic [7:0] f [9];
      f = '{8'h01, op, typ, 8'h00, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
      for (int i = 0; i < 8; i++) f[8] = f[8] + f[i];
      if (bad) f[8] = f[8] ^ 8'h5A;
      for (int i = 0; i < 9; i++) begin
         if (i > 0) repeat (gap) begin
            @(posedge sys_clk) #1;
            host_byte_valid = 1'b0;
            host_byte = ~host_byte;
         end
         @(posedge sys_clk) #1;
         host_byte_valid = 1'b1;
         host_byte = f[i];
      end
      @(posedge sys_clk) #1;
      host_byte_valid = 1'b0;
      // released lane must not keep showing the last byte
      host_byte = ~host_byte;
   endtask
endmodule

// File: tb_interrupt_control_instructions.sv
`timescale 1ns/1ps
module tb_interrupt_control_instructions;
   logic sys_clk, nrst, hv, pv, lv;
   logic [7:0] hb, p_op, p_ty, c_fl, l_fl, rs, uf_num;
   logic [31:0] p_val, c_ac, c_x0, c_x1, c_x2, c_x3, l_ac, l_x0, l_x1, l_x2, l_x3;
   logic [15:0] c_pc, irq, ien, l_pc;
   logic rv, ufv, gen, inh;
   logic [2:0] ufn;
   int error_cnt = 0;
   int n_checks = 0;
   int uf_cnt = 0;
   // ****************************************
   // clock, reset, instances
   // ****************************************
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   host_link_model host (.sys_clk(sys_clk), .host_byte_valid(hv), .host_byte(hb));
   intr_ctrl dut (.sys_clk(sys_clk), .nrst(nrst), .host_byte_valid(hv), .host_byte(hb), .prog_valid(pv),
      .prog_opcode(p_op), .prog_type(p_ty), .prog_value(p_val), .cur_accu(c_ac), .cur_xreg0(c_x0),
      .cur_xreg1(c_x1), .cur_xreg2(c_x2), .cur_xreg3(c_x3), .cur_flags(c_fl), .cur_pc(c_pc), .irq_req(irq),
      .reply_valid(rv), .reply_status(rs), .user_func_valid(ufv), .user_func_num(ufn), .irq_enable(ien),
      .global_enable(gen), .in_handler(inh), .load_valid(lv), .load_pc(l_pc), .load_accu(l_ac),
      .load_xreg0(l_x0), .load_xreg1(l_x1), .load_xreg2(l_x2), .load_xreg3(l_x3), .load_flags(l_fl));
   always @(posedge sys_clk) if (ufv === 1'b1) begin
      uf_cnt <= uf_cnt + 1;
      uf_num <= {5'h00, ufn};
   end
   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic hcmd(input logic [7:0] op, typ, input logic [31:0] val, input logic bad, input logic [7:0] st);
      host.send(op, typ, val, bad, n_checks % 3);
      // reply pulse stands in the second cycle after the checksum byte
      chk(rv, 1'b0);
      @(posedge sys_clk) #1;
      chk(rv, 1'b1);
      chk(rs, st);
      @(posedge sys_clk) #1;
      chk(rv, 1'b0);
   endtask
   task automatic pcmd(input logic [7:0] op, typ, input logic [31:0] val);
      @(posedge sys_clk) #1;
      pv = 1'b1;
      p_op = op;
      p_ty = typ;
      p_val = val;
      @(posedge sys_clk) #1;
      pv = 1'b0;
      p_val = ~val;
   endtask
   // bounded wait; entry needs 3 cycles, a return pulse already stands when pcmd returns
   task automatic wait_load(input logic exp);
      logic seen;
      seen = (lv === 1'b1);
      repeat (8) if (!seen) begin
         @(posedge sys_clk) #1;
         seen = (lv === 1'b1);
      end
      chk(seen, exp);
   endtask
   task automatic final_report;
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_host;
      logic [15:0] m;
      m = 16'h0000;
      for (int n = 0; n < 16; n++) begin
         m = m | (16'h0001 << n);
         hcmd(intr_pkg::OP_ENABLE, 8'(n), 32'h0, 1'b0, intr_pkg::STATUS_OK);
         chk(ien, m);
      end
      hcmd(intr_pkg::OP_ENABLE, 8'hFF, 32'h0, 1'b0, intr_pkg::STATUS_OK);
      chk(gen, 1'b1);
      hcmd(intr_pkg::OP_DISABLE, 8'h03, 32'h1234_5678, 1'b0, intr_pkg::STATUS_OK);
      chk(ien, 16'hFFF7);
      chk(gen, 1'b1);
      hcmd(8'h1A, 8'hFF, 32'h0, 1'b0, intr_pkg::STATUS_OK);
      chk(gen, 1'b0);
      chk(ien, 16'hFFF7);
   endtask
   task automatic t_refuse;
      int c0;
      hcmd(intr_pkg::OP_ENABLE, 8'hFF, 32'h0, 1'b1, intr_pkg::STATUS_BAD_SUM);
      chk(gen, 1'b0);
      hcmd(intr_pkg::OP_VECTOR, 8'h05, 32'h0077, 1'b0, intr_pkg::STATUS_BAD_MODE);
      hcmd(intr_pkg::OP_RETURN, 8'hFF, 32'h0, 1'b0, intr_pkg::STATUS_BAD_MODE);
      c0 = uf_cnt;
      hcmd(8'h30, 8'h00, 32'h0, 1'b0, intr_pkg::STATUS_BAD_CMD);
      chk(uf_cnt - c0, 0);
      for (int k = 0; k < 8; k++) begin
         c0 = uf_cnt;
         hcmd(8'h40 + 8'(k), 8'h00, 32'h0, 1'b0, intr_pkg::STATUS_OK);
         chk(uf_cnt - c0, 1);
         chk(uf_num, k);
      end
   endtask
   task automatic t_irq;
      // handler entry label is the routine's first instruction
      pcmd(intr_pkg::OP_VECTOR, 8'h05, 32'h0000_1234);
      pcmd(intr_pkg::OP_VECTOR, 8'h05, 32'h0000_0ABC);
      pcmd(intr_pkg::OP_ENABLE, 8'hFF, 32'h0);
      // main flow never runs into the handler; only entry reaches it
      irq = 16'h0020;
      wait_load(1'b1);
      chk(l_pc, 16'h0ABC);
      chk(l_ac, c_ac);
      chk(l_fl, c_fl);
      chk({l_x0[3:0], l_x1[3:0], l_x2[3:0], l_x3[3:0]}, 16'h1234);
      chk(inh, 1'b1);
      @(posedge sys_clk) #1;
      chk(lv, 1'b0);
      irq = 16'h0000;
      {c_pc, c_ac, c_x0, c_x1, c_x2, c_x3, c_fl} = '1;
      // every handler finishes with the return code
      pcmd(intr_pkg::OP_RETURN, 8'hFF, 32'h0);
      wait_load(1'b1);
      chk(inh, 1'b0);
      chk({l_pc, l_fl}, 24'h0321_5C);
      chk(l_ac ^ l_x0 ^ l_x1 ^ l_x2 ^ l_x3, 32'hC0DE_0000 ^ 32'h1 ^ 32'h2 ^ 32'h3 ^ 32'h4);
      chk({l_x0[3:0], l_x1[3:0], l_x2[3:0], l_x3[3:0]}, 16'h1234);
   endtask
   task automatic t_mask;
      pcmd(intr_pkg::OP_RETURN, 8'hFF, 32'h0);
      wait_load(1'b0);
      pcmd(intr_pkg::OP_DISABLE, 8'h05, 32'hDEAD_BEEF);
      chk(ien[5], 1'b0);
      irq = 16'h0020;
      wait_load(1'b0);
      irq = 16'h0000;
      pcmd(intr_pkg::OP_ENABLE, 8'h05, 32'h0);
      pcmd(intr_pkg::OP_DISABLE, 8'hFF, 32'h0);
      chk({gen, ien[5]}, 2'b01);
      irq = 16'h0020;
      wait_load(1'b0);
      irq = 16'h0000;
   endtask
   initial begin
      #200_000;
      error_cnt++;
      final_report();
   end
   initial begin
      {nrst, pv, p_op, p_ty, p_val, irq} = '0;
      {c_ac, c_x0, c_x1, c_x2, c_x3} = {32'hC0DE_0000, 32'h1, 32'h2, 32'h3, 32'h4};
      c_fl = 8'h5C;
      c_pc = 16'h0321;
      repeat (6) @(posedge sys_clk);
      #1 nrst = 1'b1;
      chk({ien, gen, inh, rv, lv}, 20'h0);
      t_host();
      t_refuse();
      t_irq();
      t_mask();
      final_report();
   end
endmodule
